// >>> src/sarpr_defines.svh
`ifndef SARPR_DEFINES_SVH
`define SARPR_DEFINES_SVH
`define SARPR_CLK_PERIOD_PS 25000
`define SARPR_CONVERSION_START_N_MIN_PS 20000
`define SARPR_CONVERSION_START_N_CYC ((`SARPR_CONVERSION_START_N_MIN_PS + `SARPR_CLK_PERIOD_PS - 1) / `SARPR_CLK_PERIOD_PS)
`define SARPR_CONV_MAX_PS 610000
`define SARPR_CONV_CYC (`SARPR_CONV_MAX_PS / `SARPR_CLK_PERIOD_PS)
`define SARPR_ACQ_MIN_PS 150000
`define SARPR_ACQ_CYC ((`SARPR_ACQ_MIN_PS + `SARPR_CLK_PERIOD_PS - 1) / `SARPR_CLK_PERIOD_PS)
`define SARPR_QUIET_PRE_PS 100000
`define SARPR_QUIET_PRE_CYC ((`SARPR_QUIET_PRE_PS + `SARPR_CLK_PERIOD_PS - 1) / `SARPR_CLK_PERIOD_PS)
`define SARPR_QUIET_POST_PS 40000
`define SARPR_QUIET_POST_CYC ((`SARPR_QUIET_POST_PS + `SARPR_CLK_PERIOD_PS - 1) / `SARPR_CLK_PERIOD_PS)
`define SARPR_RST_MIN_PS 20000
`define SARPR_RST_CYC ((`SARPR_RST_MIN_PS + `SARPR_CLK_PERIOD_PS - 1) / `SARPR_CLK_PERIOD_PS)
`define SARPR_RESUME_PS 20000
`define SARPR_RESUME_CYC ((`SARPR_RESUME_PS + `SARPR_CLK_PERIOD_PS - 1) / `SARPR_CLK_PERIOD_PS)
`define SARPR_WARMUP_CONV 3
`define SARPR_LOW_FILL 8'hff
`endif

// >>> src/sarpr_device.sv
`timescale 1ns/1ps
`include "sarpr_defines.svh"
module sarpr_device
   import sarpr_pkg::*;
#(
   parameter int CONV_CYCLES = `SARPR_CONV_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // link
   sarpr_link_if.device link,
   // analog model input
   input wire logic [15:0] analog_code,
   // status
   output logic sampling,
   output logic [15:0] held_code
);
   localparam int LANES = 2;
   // counter is six bits wide; longer conversions would wrap
   if (CONV_CYCLES < 1 || CONV_CYCLES > `SARPR_CONV_CYC)
   begin : g_bad_conv
      $error("bad conversion length");
   end
   if (CONV_CYCLES > 63)
   begin : g_conv_wide
      $error("conversion length exceeds counter");
   end
   if (LANES * 8 != $bits(held_code))
   begin : g_bad_lanes
      $error("byte lanes must cover the result");
   end
   sarpr_dev_state_t st_r, st_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic start_d_r, start_d_nxt;
   logic cs_d_r, cs_d_nxt;
   logic [15:0] bus_sel;
   logic [15:0] hold_r, hold_nxt, res_r, res_nxt, bus_r, bus_nxt;
   logic busy_r, busy_nxt, oe_r, oe_nxt, samp_r, samp_nxt;
   logic start_fall, cs_fall, in_rst;
   always_comb
   begin
      start_fall = start_d_r && !link.conversion_start_n;
      cs_fall = cs_d_r && !link.chip_select_n;
      // link reset acts like core reset, clear wins
      in_rst = srst || !link.reset_n;
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      hold_nxt = hold_r;
      res_nxt = res_r;
      busy_nxt = busy_r;
      samp_nxt = samp_r;
      case (st_r)
         DEV_RESUME:
         begin
            // first sample after delay
            // one resume cycle stands for the restart delay
            if (cnt_r >= 6'(`SARPR_RESUME_CYC - 1))
            begin
               st_nxt = DEV_SAMPLE;
               samp_nxt = 1'b1;
            end
            else
               cnt_nxt = cnt_r + 6'h01;
         end
         DEV_SAMPLE, DEV_WAIT_CS:
         begin
            if (start_fall && !link.chip_select_n)
            begin
               hold_nxt = analog_code;
               busy_nxt = 1'b1;
               samp_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = DEV_CONVERT;
            end
            else if (st_r == DEV_WAIT_CS && cs_fall)
            begin
               samp_nxt = 1'b1;
               st_nxt = DEV_SAMPLE;
            end
         end
         DEV_CONVERT:
         begin
            // starts arriving mid-conversion are ignored
            // internal bounded count
            if (cnt_r >= 6'(CONV_CYCLES - 1))
            begin
               res_nxt = hold_r;
               busy_nxt = 1'b0;
               // later of busy and cs falls
               if (!link.chip_select_n)
               begin
                  samp_nxt = 1'b1;
                  st_nxt = DEV_SAMPLE;
               end
               else
                  st_nxt = DEV_WAIT_CS;
            end
            else
               cnt_nxt = cnt_r + 6'h01;
         end
         default:
            // stray codes recover through resume
            st_nxt = DEV_RESUME;
      endcase
   end
   always_ff @(posedge core_clk)
   begin
      if (in_rst)
      begin
         st_r <= DEV_RESUME;
         cnt_r <= '0;
         hold_r <= '0;
         res_r <= '0;
         busy_r <= 1'b0;
         samp_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         hold_r <= hold_nxt;
         res_r <= res_nxt;
         busy_r <= busy_nxt;
         samp_r <= samp_nxt;
      end
   end
   // edge detectors idle high so reset never fakes a fall
   always_comb
   begin
      start_d_nxt = link.conversion_start_n;
      cs_d_nxt = link.chip_select_n;
   end
   always_ff @(posedge core_clk)
   begin
      if (in_rst)
      begin
         start_d_r <= 1'b1;
         cs_d_r <= 1'b1;
      end
      else
      begin
         start_d_r <= start_d_nxt;
         cs_d_r <= cs_d_nxt;
      end
   end
   // drive only with cs and rd low
   always_comb
   begin
      oe_nxt = !link.chip_select_n && !link.read_strobe_n;
      // idle latch held at zero so a fresh read never shows stale data
      bus_nxt = oe_nxt ? bus_sel : 16'h0000;
   end
   for (genvar lane = 0; lane < LANES; lane++)
   begin : g_lane
      // upper lane carries the low byte when byte select is high
      assign bus_sel[lane*8 +: 8] = !link.byte_select ? res_nxt[lane*8 +: 8] :
         (lane == LANES - 1) ? res_nxt[7:0] : 8'(`SARPR_LOW_FILL);
   end
   always_ff @(posedge core_clk)
   begin
      if (in_rst)
      begin
         oe_r <= 1'b0;
         bus_r <= '0;
      end
      else
      begin
         oe_r <= oe_nxt;
         bus_r <= bus_nxt;
      end
   end
   // every output below comes straight from a register
   assign link.busy = busy_r;
   assign link.output_bus_out = bus_r;
   assign link.output_bus_oe = oe_r;
   assign sampling = samp_r;
   assign held_code = hold_r;
endmodule : sarpr_device

// >>> src/sarpr_fifo.sv
`timescale 1ns/1ps
module sarpr_fifo
   import sarpr_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
   begin : g_bad_depth
      $error("depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic push, pop;
   always_comb
   begin
      in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
      out_valid = wr_r != rd_r;
      out_data = mem_r[rd_r[AW-1:0]];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
   end
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
      if (push) mem_r[wr_r[AW-1:0]] <= in_data;
   end
endmodule : sarpr_fifo

// >>> src/sarpr_host.sv
`timescale 1ns/1ps
`include "sarpr_defines.svh"
module sarpr_host
   import sarpr_pkg::*;
#(
   parameter int FIFO_DEPTH = 8,
   parameter bit BYTE_MODE = 1'b0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // link
   sarpr_link_if.host link,
   // user control
   input wire logic run,
   output logic warm,
   // result stream
   output logic res_valid,
   input wire logic res_ready,
   output logic [15:0] res_data
);
   sarpr_host_state_t st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [1:0] warm_r, warm_nxt;
   logic warm_out_r, warm_out_nxt;
   logic start_n_r, start_n_nxt, cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, byte_r, byte_nxt;
   logic rst_n_r, rst_n_nxt, push_r, push_nxt;
   logic [15:0] word_r, word_nxt;
   logic f_ready, f_valid;
   logic [15:0] f_data;
   logic vout_r;
   logic [15:0] dout_r;
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r + 4'h1;
      warm_nxt = warm_r;
      start_n_nxt = 1'b1;
      cs_n_nxt = cs_n_r;
      rd_n_nxt = 1'b1;
      byte_nxt = byte_r;
      rst_n_nxt = 1'b1;
      push_nxt = 1'b0;
      word_nxt = word_r;
      case (st_r)
         HST_RESET:
         begin
            rst_n_nxt = 1'b0;
            if (cnt_r >= 4'(`SARPR_RST_CYC + `SARPR_RESUME_CYC))
            begin
               rst_n_nxt = 1'b1;
               cnt_nxt = '0;
               st_nxt = HST_ACQ;
            end
         end
         HST_ACQ:
         begin
            cs_n_nxt = 1'b0;
            if (cnt_r >= 4'(`SARPR_ACQ_CYC + `SARPR_QUIET_PRE_CYC) && run && f_ready)
            begin
               start_n_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = HST_START;
            end
         end
         HST_START:
         begin
            start_n_nxt = cnt_r >= 4'(`SARPR_CONVERSION_START_N_CYC - 1);
            if (cnt_r >= 4'(`SARPR_QUIET_POST_CYC + 1))
               st_nxt = HST_BUSY;
         end
         HST_BUSY:
            if (!link.busy)
            begin
               rd_n_nxt = 1'b0;
               byte_nxt = 1'b0;
               cnt_nxt = '0;
               st_nxt = HST_READ_HI;
            end
         HST_READ_HI:
         begin
            rd_n_nxt = 1'b0;
            if (cnt_r == 4'h2)
            begin
               word_nxt = link.output_bus;
               byte_nxt = BYTE_MODE;
               cnt_nxt = '0;
               st_nxt = BYTE_MODE ? HST_READ_LO : HST_ACQ;
               push_nxt = !BYTE_MODE && warm_r == 2'(`SARPR_WARMUP_CONV);
               if (!BYTE_MODE && warm_r != 2'(`SARPR_WARMUP_CONV)) warm_nxt = warm_r + 2'h1;
            end
         end
         HST_READ_LO:
         begin
            rd_n_nxt = 1'b0;
            if (cnt_r == 4'h2)
            begin
               word_nxt = {word_r[15:8], link.output_bus[15:8]};
               byte_nxt = 1'b0;
               rd_n_nxt = 1'b1;
               cnt_nxt = '0;
               st_nxt = HST_ACQ;
               push_nxt = warm_r == 2'(`SARPR_WARMUP_CONV);
               if (warm_r != 2'(`SARPR_WARMUP_CONV)) warm_nxt = warm_r + 2'h1;
            end
         end
         default:
            st_nxt = HST_RESET;
      endcase
      warm_out_nxt = warm_nxt == 2'(`SARPR_WARMUP_CONV);
   end
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         st_r <= HST_RESET;
         cnt_r <= '0;
         warm_r <= '0;
         warm_out_r <= 1'b0;
         start_n_r <= 1'b1;
         cs_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         byte_r <= 1'b0;
         rst_n_r <= 1'b0;
         push_r <= 1'b0;
         word_r <= '0;
         vout_r <= 1'b0;
         dout_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         warm_r <= warm_nxt;
         warm_out_r <= warm_out_nxt;
         start_n_r <= start_n_nxt;
         cs_n_r <= cs_n_nxt;
         rd_n_r <= rd_n_nxt;
         byte_r <= byte_nxt;
         rst_n_r <= rst_n_nxt;
         push_r <= push_nxt;
         word_r <= word_nxt;
         if (!vout_r || res_ready)
         begin
            vout_r <= f_valid;
            dout_r <= f_data;
         end
      end
   end
   // start is only issued with fifo room, so no push is lost
   sarpr_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .srst(srst),
      .in_valid(push_r),
      .in_ready(f_ready),
      .in_data(word_r),
      .out_valid(f_valid),
      .out_ready(!vout_r || res_ready),
      .out_data(f_data)
   );
   assign link.conversion_start_n = start_n_r;
   assign link.chip_select_n = cs_n_r;
   assign link.read_strobe_n = rd_n_r;
   assign link.byte_select = byte_r;
   assign link.reset_n = rst_n_r;
   assign warm = warm_out_r;
   assign res_valid = vout_r;
   assign res_data = dout_r;
endmodule : sarpr_host

// >>> src/sarpr_link_if.sv
`timescale 1ns/1ps
interface sarpr_link_if;
   logic conversion_start_n;
   logic chip_select_n;
   logic read_strobe_n;
   logic byte_select;
   logic reset_n;
   logic busy;
   logic [15:0] output_bus_out;
   logic output_bus_oe;
   logic [15:0] output_bus;
   assign output_bus = output_bus_oe ? output_bus_out : 16'hffff;
   modport device (
      input conversion_start_n, chip_select_n, read_strobe_n, byte_select, reset_n,
      output busy, output_bus_out, output_bus_oe
   );
   modport host (
      output conversion_start_n, chip_select_n, read_strobe_n, byte_select, reset_n,
      input busy, output_bus
   );
endinterface : sarpr_link_if

// >>> src/sarpr_pkg.sv
package sarpr_pkg;
   typedef enum logic [3:0] {
      DEV_RESUME = 4'h1,
      DEV_SAMPLE = 4'h2,
      DEV_CONVERT = 4'h4,
      DEV_WAIT_CS = 4'h8
   } sarpr_dev_state_t;
   typedef enum logic [5:0] {
      HST_RESET = 6'h01,
      HST_ACQ = 6'h02,
      HST_START = 6'h04,
      HST_BUSY = 6'h08,
      HST_READ_HI = 6'h10,
      HST_READ_LO = 6'h20
   } sarpr_host_state_t;
endpackage : sarpr_pkg

// >>> verif/sar_adc_parallel_read_control_tb_top.sv
`timescale 1ns/1ps
module sar_adc_parallel_read_control_tb_top;
   import sarpr_pkg::*;
   localparam int CONV = 4;
   localparam int FDEPTH = 8;
   logic core_clk;
   logic srst;
   logic run;
   logic res_ready;
   logic [15:0] analog_code;
   logic [1:0] warm;
   logic [1:0] res_valid;
   logic [15:0] res_data [2];
   logic [15:0] rxq [2][$];
   logic [1:0] sampling;
   logic [15:0] held_code [2];
   logic bs_q;
   logic [15:0] codes [5] = '{16'h0000, 16'h8000, 16'h7fff, 16'hffff, 16'h12c3};
   int fail_count;
   int total_checks;
   int cycles;
   int n;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : pair
         sarpr_link_if sarpr_link_if_inst ();
         sarpr_device #(.CONV_CYCLES(CONV)) sarpr_device_inst (.core_clk(core_clk),
            .srst(srst), .link(sarpr_link_if_inst), .analog_code(analog_code),
            .sampling(sampling[g]), .held_code(held_code[g]));
         sarpr_host #(.FIFO_DEPTH(FDEPTH), .BYTE_MODE(g == 1)) sarpr_host_inst (
            .core_clk(core_clk), .srst(srst), .link(sarpr_link_if_inst), .run(run),
            .warm(warm[g]), .res_valid(res_valid[g]), .res_ready(res_ready),
            .res_data(res_data[g]));
         always @(posedge core_clk)
         begin
            if (res_valid[g] && res_ready)
            begin
               rxq[g].push_back(res_data[g]);
            end
         end
      end
   endgenerate
   sarpr_link_monitor #(.CONV_CYCLES(CONV)) sarpr_link_monitor_inst (.core_clk(core_clk),
      .srst(srst), .conversion_start_n(pair[0].sarpr_link_if_inst.conversion_start_n),
      .chip_select_n(pair[0].sarpr_link_if_inst.chip_select_n),
      .read_strobe_n(pair[0].sarpr_link_if_inst.read_strobe_n),
      .reset_n(pair[0].sarpr_link_if_inst.reset_n), .busy(pair[0].sarpr_link_if_inst.busy),
      .output_bus_out(pair[0].sarpr_link_if_inst.output_bus_out),
      .output_bus_oe(pair[0].sarpr_link_if_inst.output_bus_oe));
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : check_word
   task automatic check_flag(input logic got, input logic exp, input string what);
      check_word({15'h0000, got}, {15'h0000, exp}, what);
   endtask : check_flag
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   task automatic take(input int idx, output logic [15:0] word);
      int k;
      k = 0;
      while (rxq[idx].size() == 0 && k < 2000)
      begin
         @(posedge core_clk);
         k++;
      end
      word = (rxq[idx].size() != 0) ? rxq[idx].pop_front() : 16'hxxxx;
   endtask : take
   // two words dropped: they may be sampled before the code changed
   task automatic expect_code(input logic [15:0] code);
      logic [15:0] w;
      @(posedge core_clk);
      analog_code <= code;
      rxq[0].delete();
      rxq[1].delete();
      for (int i = 0; i < 2; i++)
      begin
         take(i, w);
         take(i, w);
         take(i, w);
         check_word(w, code, "stream word");
         check_word(held_code[i], code, "held code");
      end
   endtask : expect_code
   task automatic wait_warm();
      int k;
      k = 0;
      while (warm !== 2'b11 && k < 3000)
      begin
         @(negedge core_clk);
         k++;
      end
      check_flag(warm[0] & warm[1], 1'b1, "warm after three");
   endtask : wait_warm
   // byte high puts all ones on the lower lane of the byte-wide pair
   always @(posedge core_clk)
   begin
      bs_q <= pair[1].sarpr_link_if_inst.byte_select;
      if (pair[1].sarpr_link_if_inst.output_bus_oe && bs_q)
      begin
         check_word({8'h00, pair[1].sarpr_link_if_inst.output_bus[7:0]}, 16'h00ff, "fill");
      end
   end
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count++;
         results();
      end
   end
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial
   begin
      srst = 1'b1;
      run = 1'b0;
      res_ready = 1'b1;
      analog_code = 16'h0000;
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      run <= 1'b1;
      @(negedge core_clk);
      check_flag(warm[0], 1'b0, "warm early");
      wait_warm();
      $display("test warm-up done");
      foreach (codes[i]) expect_code(codes[i]);
      $display("test codes done");
      res_ready <= 1'b0;
      repeat (600) @(posedge core_clk);
      rxq[0].delete();
      @(negedge core_clk);
      check_flag(res_valid[0], 1'b1, "stalled valid");
      check_flag(pair[0].sarpr_link_if_inst.busy, 1'b0, "no start when full");
      check_flag(sampling[0], 1'b1, "sampling while idle");
      @(posedge core_clk);
      res_ready <= 1'b1;
      // fifo plus output register drain one word a cycle
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      check_word(16'(rxq[0].size()), 16'(FDEPTH + 1), "held count");
      repeat (30) @(posedge core_clk);
      check_flag(rxq[0].size() >= FDEPTH, 1'b1, "buffered count");
      n = rxq[0].size();
      repeat (n) check_word(rxq[0].pop_front(), 16'h12c3, "buffered word");
      run <= 1'b0;
      repeat (60) @(posedge core_clk);
      @(negedge core_clk);
      check_flag(res_valid[0] | res_valid[1], 1'b0, "stream drained");
      @(posedge core_clk);
      run <= 1'b1;
      $display("test stall done");
      n = 0;
      while (pair[0].sarpr_link_if_inst.busy !== 1'b1 && n < 500)
      begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      srst <= 1'b1;
      @(posedge core_clk);
      srst <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      check_flag(pair[0].sarpr_link_if_inst.busy, 1'b0, "busy after reset");
      check_word(pair[0].sarpr_link_if_inst.output_bus_out, 16'h0000, "latch");
      check_flag(warm[0], 1'b0, "warm cleared");
      wait_warm();
      expect_code(16'h3c81);
      $display("test reset done");
      results();
   end
endmodule : sar_adc_parallel_read_control_tb_top

// >>> verif/sarpr_link_monitor.sv
`timescale 1ns/1ps
module sarpr_link_monitor
#(
   parameter int CONV_CYCLES = 24
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // link
   input wire logic conversion_start_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic reset_n,
   input wire logic busy,
   input wire logic [15:0] output_bus_out,
   input wire logic output_bus_oe
);
   logic [7:0] busy_cnt_r;
   logic [7:0] busy_cnt_nxt;
   logic [3:0] idle_cnt_r;
   logic [3:0] idle_cnt_nxt;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // idle count saturates so long gaps never wrap
   always_comb
   begin
      busy_cnt_nxt = busy ? busy_cnt_r + 8'h01 : 8'h00;
      idle_cnt_nxt = busy ? 4'h0 : idle_cnt_r + {3'h0, idle_cnt_r != 4'hf};
   end
   always_ff @(posedge core_clk)
   begin
      busy_cnt_r <= srst ? 8'h00 : busy_cnt_nxt;
      idle_cnt_r <= srst ? 4'h0 : idle_cnt_nxt;
   end
   chk_busy_rise: assert property (
      $fell(conversion_start_n) && !chip_select_n && !busy && reset_n |=> busy)
      else $error("busy did not follow start");
   chk_conv_bound: assert property (busy_cnt_r <= CONV_CYCLES)
      else $error("conversion too long");
   chk_cs_refused: assert property (
      $fell(conversion_start_n) && chip_select_n && !busy |=> !busy)
      else $error("start taken without select");
   chk_bus_gate: assert property (
      output_bus_oe |-> $past(chip_select_n) == 1'b0 && $past(read_strobe_n) == 1'b0)
      else $error("bus driven while not read");
   chk_reset_abort: assert property (!reset_n |=> !busy && !output_bus_oe)
      else $error("reset did not abort");
   chk_latch_clear: assert property (!reset_n |=> output_bus_out == 16'h0000)
      else $error("latches not cleared");
   chk_quiet_before: assert property ($fell(conversion_start_n) |->
      $past(read_strobe_n, 1) && $past(read_strobe_n, 2) && $past(read_strobe_n, 3)
      && $past(read_strobe_n, 4))
      else $error("read before start");
   chk_quiet_after: assert property ($fell(conversion_start_n) |-> read_strobe_n [*3])
      else $error("read after start");
   chk_start_select: assert property ($fell(conversion_start_n) |-> !chip_select_n)
      else $error("start without select");
   chk_acq_time: assert property ($fell(conversion_start_n) |-> idle_cnt_r >= 4'h6)
      else $error("acquisition too short");
   cover property ($fell(busy));
   cover property (!reset_n ##1 reset_n);
   cover property (output_bus_oe);
endmodule : sarpr_link_monitor
